// ---- inc/ldo_limit_map.vh ----
// Register offsets, field positions and reset values of the
// regulator voltage-select and ceiling register slice.
// Included by the slice's design files; definitions only.
`ifndef LDO_LIMIT_MAP_VH
`define LDO_LIMIT_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_REG1_CEILING   8'h12
`define OFS_REG2_PRIMARY   8'h13
`define OFS_REG2_ALTERNATE 8'h14
`define OFS_REG2_CEILING   8'h15
`define OFS_REG3_PRIMARY   8'h16
`define OFS_REG3_ALTERNATE 8'h17
`define OFS_REG3_CEILING   8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CODE_MSB       5
`define CODE_LSB       0
`define SELECT_BIT     6
`define ECONOMY_BIT    6
`define ENABLE_BIT     7

// ----------------------------------------------------------------
// Fixed reset values, ceiling lock codes and the unmapped read value
// ----------------------------------------------------------------
`define SELECT_RESET   1'h0
`define ECONOMY_RESET  1'h0
`define CEIL_ALL_ONES  6'h3F
`define CEIL_ALL_ZEROS 6'h00
`define READ_UNMAPPED  8'h00

`endif

// ---- sim/ctrl_host.sv ----
// Control-port host model: one strobe per access, gap between.
// Assumes clk of the register slice.
`timescale 1ns/1ns
`default_nettype none
module ctrl_host (
  input  wire logic       clk,
  output var  logic       reg_wr_en,
  output var  logic       reg_rd_en,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wr_data
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'hFF;
    reg_wr_data = 8'h00;
  end
  // Idle bus shows inverted values, never the last ones
  task automatic go(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    reg_wr_en <= w;
    reg_rd_en <= !w;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    reg_wr_data <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, d);
    go(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    go(1'b0, a, 8'h00);
  endtask
endmodule // ctrl_host
`default_nettype wire

// ---- sim/ldo_voltage_limit_regs_properties.sv ----
// Checker for the regulator ceiling register slice.
// Sees only the top module's ports; bound below.
`timescale 1ns/1ns
`default_nettype none
module ldo_voltage_limit_regs_properties (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       reg_wr_en,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data_r,
  input wire logic       reg_rd_valid_r,
  input wire logic       otp_reload,
  input wire logic [5:0] otp_reg1_ceiling,
  input wire logic       off_state_force,
  input wire logic [5:0] reg1_ceiling_r,
  input wire logic       reg1_ceiling_locked_r,
  input wire logic       reg2_on_r,
  input wire logic       reg3_on_r
);
  logic [5:0] wr_code;
  logic       ceil_wr;
  assign wr_code = reg_wr_data[5:0];
  assign ceil_wr = rst_n && reg_wr_en && reg_addr == 8'h12 && !otp_reload;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_read_answer: assert property (reg_rd_en |=> reg_rd_valid_r)
    else $error("read not answered");
  a_no_stray_valid: assert property (!reg_rd_en |=> !reg_rd_valid_r)
    else $error("stray read valid");
  a_unmapped_zero: assert property (reg_rd_en && (reg_addr < 8'h12 || reg_addr > 8'h18) |=>
    reg_rd_data_r == 8'h00)
    else $error("unmapped read not zero");
  a_ceil_reserved: assert property (reg_rd_en && reg_addr inside {8'h12, 8'h15, 8'h18} |=>
    reg_rd_data_r[7:6] == 2'b00)
    else $error("ceiling reserved bits set");
  a_prim_reserved: assert property (reg_rd_en && reg_addr inside {8'h13, 8'h16} |=> !reg_rd_data_r[7])
    else $error("primary reserved bit set");
  a_forced_off: assert property (off_state_force |=> !reg2_on_r && !reg3_on_r)
    else $error("regulator on while forced off");
  a_lock_holds: assert property (rst_n && reg1_ceiling_locked_r && !otp_reload |=>
    reg1_ceiling_locked_r && $stable(reg1_ceiling_r))
    else $error("locked ceiling changed");
  a_lock_sets: assert property (ceil_wr && !reg1_ceiling_locked_r |=> reg1_ceiling_r == $past(wr_code)
    && reg1_ceiling_locked_r == ($past(wr_code) != 6'h00 && $past(wr_code) != 6'h3F))
    else $error("unlocked ceiling write wrong");
  a_reload_loads: assert property (otp_reload |=> reg1_ceiling_r == $past(otp_reg1_ceiling))
    else $error("reload did not load ceiling");
endmodule // ldo_voltage_limit_regs_properties
bind ldo_voltage_limit_regs ldo_voltage_limit_regs_properties ldo_voltage_limit_regs_properties_inst (.*);
`default_nettype wire

// ---- sim/test_ldo_voltage_limit_regs.sv ----
// Self-checking bench of the regulator ceiling register slice.
// Assumes ctrl_host and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_ldo_voltage_limit_regs;
  logic clk, rst_n, reg_wr_en, reg_rd_en, reg_rd_valid_r, otp_reload, otp_reg2_enable, otp_reg3_enable;
  logic off_state_force, reg1_ceiling_locked_r, reg2_on_r, reg2_economy_r, reg2_ceiling_locked_r;
  logic reg3_on_r, reg3_economy_r, reg3_ceiling_locked_r;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data_r;
  logic [5:0] otp_reg1_ceiling, otp_reg2_primary, otp_reg2_alternate, otp_reg2_ceiling, otp_reg3_primary;
  logic [5:0] otp_reg3_alternate, otp_reg3_ceiling, reg1_ceiling_r, reg2_vout_code_r, reg3_vout_code_r;
  int failures = 0;
  int checks_done = 0;
  logic [7:0] exp_q[$];
  logic [7:0] ex[9];
  ldo_voltage_limit_regs ldo_voltage_limit_regs_inst (.*);
  ctrl_host ctrl_host_inst (.*);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [7:0] e, s);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    ctrl_host_inst.rd(a);
  endtask
  function automatic logic [5:0] m(input logic [5:0] c, l);
    return (c > l) ? l : c;
  endfunction
  task automatic finish_test;
    if (exp_q.size() != 0) failures++;
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) if (reg_rd_valid_r === 1'b1) chk("read", exp_q.pop_front(), reg_rd_data_r);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    finish_test;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h44CB));
    rst_n = 1'b0;
    otp_reload = 1'b0;
    off_state_force = 1'b0;
    otp_reg1_ceiling = 6'h3F;
    otp_reg2_ceiling = 6'h3F;
    otp_reg3_ceiling = 6'h20;
    {otp_reg2_primary, otp_reg2_alternate, otp_reg3_primary, otp_reg3_alternate} = 24'($urandom);
    {otp_reg2_enable, otp_reg3_enable} = 2'b10;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("vout2", otp_reg2_primary, reg2_vout_code_r);
    chk("vout3", m(otp_reg3_primary, 6'h20), reg3_vout_code_r);
    chk("locks", 8'h01, {reg2_ceiling_locked_r, reg3_ceiling_locked_r});
    ex = '{8'h00, 8'h3F, {2'b00, otp_reg2_primary}, {otp_reg2_enable, 1'b0, otp_reg2_alternate}, 8'h3F,
           {2'b00, m(otp_reg3_primary, 6'h20)}, {otp_reg3_enable, 1'b0, m(otp_reg3_alternate, 6'h20)}, 8'h20, 8'h00};
    for (int i = 0; i < 9; i++) rd(8'(8'h11 + i), ex[i]);
    ctrl_host_inst.wr(8'h15, 8'h10);
    ctrl_host_inst.wr(8'h15, 8'h3F);
    rd(8'h15, 8'h10);
    ctrl_host_inst.wr(8'h13, 8'h7F);
    rd(8'h13, 8'h50);
    ctrl_host_inst.wr(8'h14, 8'hC5);
    rd(8'h14, 8'hC5);
    repeat (3) @(posedge clk);
    chk("alt", {2'b11, 6'h05}, {reg2_on_r, reg2_economy_r, reg2_vout_code_r});
    off_state_force <= 1'b1;
    repeat (3) @(posedge clk);
    chk("forced", 8'h00, {7'h00, reg2_on_r});
    off_state_force <= 1'b0;
    ctrl_host_inst.wr(8'h14, 8'h05);
    repeat (3) @(posedge clk);
    chk("off", 8'h00, {7'h00, reg2_on_r});
    ctrl_host_inst.wr(8'h18, 8'h30);
    rd(8'h18, 8'h20);
    otp_reg3_ceiling <= 6'h3F;
    otp_reload <= 1'b1;
    @(posedge clk);
    otp_reload <= 1'b0;
    @(posedge clk);
    chk("reload", 8'h00, {6'h00, reg2_ceiling_locked_r, reg3_ceiling_locked_r});
    ctrl_host_inst.wr(8'h18, 8'h08);
    rd(8'h18, 8'h08);
    ctrl_host_inst.wr(8'h17, 8'h3F);
    rd(8'h17, 8'h08);
    ctrl_host_inst.wr(8'h16, 8'h41);
    ctrl_host_inst.wr(8'h17, 8'hC3);
    repeat (3) @(posedge clk);
    chk("alt3", 8'hC3, {reg3_on_r, reg3_economy_r, reg3_vout_code_r});
    ctrl_host_inst.wr(8'h12, 8'h00);
    @(posedge clk);
    chk("lock1", 8'h00, {7'h00, reg1_ceiling_locked_r});
    chk("ceil1", 8'h00, {2'b00, reg1_ceiling_r});
    ctrl_host_inst.wr(8'h12, 8'h2A);
    ctrl_host_inst.wr(8'h12, 8'h11);
    rd(8'h12, 8'h2A);
    chk("lock1on", 8'h01, {7'h00, reg1_ceiling_locked_r});
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h15, 8'h3F);
    rd(8'h13, {2'b00, otp_reg2_primary});
    repeat (5) @(posedge clk);
    finish_test;
  end
endmodule // test_ldo_voltage_limit_regs
`default_nettype wire

// ---- src/ldo_channel.v ----
// One regulator's primary, alternate and ceiling registers.
// Assumes write strobes already decoded and on the clk domain.
`timescale 1ns/1ns
`default_nettype none
`include "ldo_limit_map.vh"

module ldo_channel (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       otp_reload,
  input  wire [5:0] otp_primary_code,
  input  wire [5:0] otp_alternate_code,
  input  wire       otp_enable,
  input  wire [5:0] otp_ceiling,
  input  wire       wr_primary,
  input  wire       wr_alternate,
  input  wire       wr_ceiling,
  input  wire [7:0] wr_data,
  input  wire       off_force,
  output wire [7:0] primary_image,
  output wire [7:0] alternate_image,
  output wire [7:0] ceiling_image,
  output reg  [5:0] vout_code_r,
  output reg        regulator_on_r,
  output reg        economy_out_r,
  output reg        ceiling_locked_r
);

  reg [5:0] primary_code_r;
  reg       register_select_r;
  reg [5:0] alternate_code_r;
  reg       enable_r;
  reg       economy_r;
  reg [5:0] ceiling_r;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [5:0] clamp;
    input [5:0] code;
    input [5:0] ceil;
    begin
      clamp = (code > ceil) ? ceil : code;
    end
  endfunction

  function locks;
    input [5:0] ceil;
    begin
      locks = (ceil != `CEIL_ALL_ONES) && (ceil != `CEIL_ALL_ZEROS);
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n || otp_reload) begin
      primary_code_r   <= clamp(otp_primary_code, otp_ceiling);
      alternate_code_r <= clamp(otp_alternate_code, otp_ceiling);
      enable_r         <= otp_enable;
      ceiling_r        <= otp_ceiling;
      ceiling_locked_r <= locks(otp_ceiling);
      if (!rst_n) begin
        register_select_r <= `SELECT_RESET;
        economy_r         <= `ECONOMY_RESET;
      end
    end else begin
      if (wr_primary) begin
        primary_code_r    <= clamp(wr_data[`CODE_MSB:`CODE_LSB], ceiling_r);
        register_select_r <= wr_data[`SELECT_BIT];
      end
      if (wr_alternate) begin
        alternate_code_r <= clamp(wr_data[`CODE_MSB:`CODE_LSB], ceiling_r);
        enable_r         <= wr_data[`ENABLE_BIT];
        economy_r        <= wr_data[`ECONOMY_BIT];
      end
      if (wr_ceiling && !ceiling_locked_r) begin
        ceiling_r        <= wr_data[`CODE_MSB:`CODE_LSB];
        ceiling_locked_r <= locks(wr_data[`CODE_MSB:`CODE_LSB]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Regulator drive
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      vout_code_r    <= 6'h00;
      regulator_on_r <= 1'h0;
      economy_out_r  <= 1'h0;
    end else begin
      vout_code_r    <= clamp(register_select_r ? alternate_code_r : primary_code_r,
                              ceiling_r);
      regulator_on_r <= enable_r & ~off_force;
      economy_out_r  <= economy_r;
    end
  end

  // ----------------------------------------------------------------
  // Read images, reserved bits zero
  // ----------------------------------------------------------------
  assign primary_image   = {1'h0, register_select_r, primary_code_r};
  assign alternate_image = {enable_r, economy_r, alternate_code_r};
  assign ceiling_image   = {2'h0, ceiling_r};

endmodule // ldo_channel

`default_nettype wire

// ---- src/ldo_voltage_limit_regs.v ----
// Voltage ceiling register of regulator 1 and the primary, alternate
// and ceiling registers of regulators 2 and 3.
// Assumes the control-port register strobes and the factory memory
// values are on the clk domain; rst_n is the power-on reset.
// The control port is a strobe back end: one access per cycle, a write
// lands at its strobe edge and a read answers one cycle later.
// Codes above a ceiling are clamped when written and again on the way
// out; a factory-memory reload keeps register select and economy.
//
// Contract
// - A written primary or alternate code above the ceiling is stored as the ceiling.
// - A ceiling other than all ones or all zeros locks the ceiling against writes.
// - Only power-on reset or a reload of factory memory releases the ceiling lock.
// - Every register returns to its defaults on power-on reset.
// - Alternate bit 7 turns the regulator off at 0 and on at 1 unless off-state forces it off.
// - Reserved upper bits read as zero and software writes zero there.
// - Primary holds a six-bit factory-default code and a select bit 6 that resets to 0.
// - Regulator 2 sits at 13h, 14h, 15h; alternate holds enable, economy and a code.
// - Regulator 3 sits at 16h, 17h, 18h with the same layout.
// - Regulator 1 ceiling sits at 12h and resets from factory memory.
// - Factory-defined fields load from factory memory after reset.
`timescale 1ns/1ns
`default_nettype none
`include "ldo_limit_map.vh"

module ldo_voltage_limit_regs (
  // ----------------------------------------------------------------
  // Clock and reset
  // ----------------------------------------------------------------
  input  wire        clk,
  input  wire        rst_n,
  // ----------------------------------------------------------------
  // Control port
  // ----------------------------------------------------------------
  input  wire        reg_wr_en,
  input  wire        reg_rd_en,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wr_data,
  output reg  [7:0]  reg_rd_data_r,
  output reg         reg_rd_valid_r,
  // ----------------------------------------------------------------
  // Factory memory and off-state
  // ----------------------------------------------------------------
  input  wire        otp_reload,
  input  wire [5:0]  otp_reg1_ceiling,
  input  wire [5:0]  otp_reg2_primary,
  input  wire [5:0]  otp_reg2_alternate,
  input  wire        otp_reg2_enable,
  input  wire [5:0]  otp_reg2_ceiling,
  input  wire [5:0]  otp_reg3_primary,
  input  wire [5:0]  otp_reg3_alternate,
  input  wire        otp_reg3_enable,
  input  wire [5:0]  otp_reg3_ceiling,
  input  wire        off_state_force,
  // ----------------------------------------------------------------
  // Regulator outputs
  // ----------------------------------------------------------------
  output reg  [5:0]  reg1_ceiling_r,
  output reg         reg1_ceiling_locked_r,
  output wire [5:0]  reg2_vout_code_r,
  output wire        reg2_on_r,
  output wire        reg2_economy_r,
  output wire        reg2_ceiling_locked_r,
  output wire [5:0]  reg3_vout_code_r,
  output wire        reg3_on_r,
  output wire        reg3_economy_r,
  output wire        reg3_ceiling_locked_r
);

  wire [7:0] reg1_ceiling_image;
  wire [7:0] reg2_primary_image;
  wire [7:0] reg2_alternate_image;
  wire [7:0] reg2_ceiling_image;
  wire [7:0] reg3_primary_image;
  wire [7:0] reg3_alternate_image;
  wire [7:0] reg3_ceiling_image;
  wire       wr_reg1_ceiling;
  wire       wr_reg2_primary;
  wire       wr_reg2_alternate;
  wire       wr_reg2_ceiling;
  wire       wr_reg3_primary;
  wire       wr_reg3_alternate;
  wire       wr_reg3_ceiling;
  wire [5:0] wr_code;
  reg  [5:0] reg1_ceiling_nxt;
  reg        reg1_ceiling_locked_nxt;
  reg  [7:0] rd_data_nxt;
  reg        rd_valid_nxt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = reg_wr_en && (addr == ofs);
    end
  endfunction

  function locks;
    input [5:0] ceil;
    begin
      locks = (ceil != `CEIL_ALL_ONES) && (ceil != `CEIL_ALL_ZEROS);
    end
  endfunction

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign wr_code           = reg_wr_data[`CODE_MSB:`CODE_LSB];
  assign wr_reg1_ceiling   = hit(reg_addr, `OFS_REG1_CEILING);
  assign wr_reg2_primary   = hit(reg_addr, `OFS_REG2_PRIMARY);
  assign wr_reg2_alternate = hit(reg_addr, `OFS_REG2_ALTERNATE);
  assign wr_reg2_ceiling   = hit(reg_addr, `OFS_REG2_CEILING);
  assign wr_reg3_primary   = hit(reg_addr, `OFS_REG3_PRIMARY);
  assign wr_reg3_alternate = hit(reg_addr, `OFS_REG3_ALTERNATE);
  assign wr_reg3_ceiling   = hit(reg_addr, `OFS_REG3_CEILING);

  // ----------------------------------------------------------------
  // Regulator 1 ceiling
  // ----------------------------------------------------------------
  always @* begin
    reg1_ceiling_nxt        = reg1_ceiling_r;
    reg1_ceiling_locked_nxt = reg1_ceiling_locked_r;
    if (!rst_n || otp_reload) begin
      reg1_ceiling_nxt        = otp_reg1_ceiling;
      reg1_ceiling_locked_nxt = locks(otp_reg1_ceiling);
    end else if (wr_reg1_ceiling && !reg1_ceiling_locked_r) begin
      reg1_ceiling_nxt        = wr_code;
      reg1_ceiling_locked_nxt = locks(wr_code);
    end
  end

  always @(posedge clk) begin
    reg1_ceiling_r        <= reg1_ceiling_nxt;
    reg1_ceiling_locked_r <= reg1_ceiling_locked_nxt;
  end

  assign reg1_ceiling_image = {2'h0, reg1_ceiling_r};

  // ----------------------------------------------------------------
  // Regulators 2 and 3
  // ----------------------------------------------------------------
  ldo_channel u_reg2 (
    .clk                (clk),
    .rst_n              (rst_n),
    .otp_reload         (otp_reload),
    .otp_primary_code   (otp_reg2_primary),
    .otp_alternate_code (otp_reg2_alternate),
    .otp_enable         (otp_reg2_enable),
    .otp_ceiling        (otp_reg2_ceiling),
    .wr_primary         (wr_reg2_primary),
    .wr_alternate       (wr_reg2_alternate),
    .wr_ceiling         (wr_reg2_ceiling),
    .wr_data            (reg_wr_data),
    .off_force          (off_state_force),
    .primary_image      (reg2_primary_image),
    .alternate_image    (reg2_alternate_image),
    .ceiling_image      (reg2_ceiling_image),
    .vout_code_r        (reg2_vout_code_r),
    .regulator_on_r     (reg2_on_r),
    .economy_out_r      (reg2_economy_r),
    .ceiling_locked_r   (reg2_ceiling_locked_r)
  );

  ldo_channel u_reg3 (
    .clk                (clk),
    .rst_n              (rst_n),
    .otp_reload         (otp_reload),
    .otp_primary_code   (otp_reg3_primary),
    .otp_alternate_code (otp_reg3_alternate),
    .otp_enable         (otp_reg3_enable),
    .otp_ceiling        (otp_reg3_ceiling),
    .wr_primary         (wr_reg3_primary),
    .wr_alternate       (wr_reg3_alternate),
    .wr_ceiling         (wr_reg3_ceiling),
    .wr_data            (reg_wr_data),
    .off_force          (off_state_force),
    .primary_image      (reg3_primary_image),
    .alternate_image    (reg3_alternate_image),
    .ceiling_image      (reg3_ceiling_image),
    .vout_code_r        (reg3_vout_code_r),
    .regulator_on_r     (reg3_on_r),
    .economy_out_r      (reg3_economy_r),
    .ceiling_locked_r   (reg3_ceiling_locked_r)
  );

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always @* begin
    rd_valid_nxt = reg_rd_en;
    rd_data_nxt  = reg_rd_data_r;
    if (reg_rd_en) begin
      case (reg_addr)
        `OFS_REG1_CEILING:   rd_data_nxt = reg1_ceiling_image;
        `OFS_REG2_PRIMARY:   rd_data_nxt = reg2_primary_image;
        `OFS_REG2_ALTERNATE: rd_data_nxt = reg2_alternate_image;
        `OFS_REG2_CEILING:   rd_data_nxt = reg2_ceiling_image;
        `OFS_REG3_PRIMARY:   rd_data_nxt = reg3_primary_image;
        `OFS_REG3_ALTERNATE: rd_data_nxt = reg3_alternate_image;
        `OFS_REG3_CEILING:   rd_data_nxt = reg3_ceiling_image;
        default:             rd_data_nxt = `READ_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      reg_rd_data_r  <= 8'h00;
      reg_rd_valid_r <= 1'h0;
    end else begin
      reg_rd_valid_r <= rd_valid_nxt;
      reg_rd_data_r  <= rd_data_nxt;
    end
  end

endmodule // ldo_voltage_limit_regs

`default_nettype wire
